// ==== hdl/dbc_ctrl.sv ====
// Control logic of the boost pre-regulator and buck post-regulator cascade
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dbc_ctrl
    import dbc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Mode controller
    input wire dbc_mode_e mode,
    input wire logic stop_cmd,
    input wire logic wake_pin,
    // Analog side
    input wire dbc_comp_s comp,
    output dbc_ctrl_s ctrl,
    output logic surge_event
);

    // ----------------------------------------------------------------
    // Comparator synchronisers
    // ----------------------------------------------------------------
    dbc_comp_s sync1_q, sync2_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= comp;
            sync2_q <= sync1_q;
        end
    end

    function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] r);
        return a == r;
    endfunction

    wire logic wr_cfg = reg_wr && addr_hit(reg_addr, DBC_ADDR_HW_CONFIG);
    wire logic wr_flt = reg_wr && addr_hit(reg_addr, DBC_ADDR_FAULT_STAT);
    wire logic wr_wk = reg_wr && addr_hit(reg_addr, DBC_ADDR_WAKE_STAT);

    // ----------------------------------------------------------------
    // Configuration register
    // ----------------------------------------------------------------
    logic [7:0] cfg_q, cfg_d;

    always_comb begin
        cfg_d = cfg_q;
        if (wr_cfg) begin
            cfg_d = reg_wdata & DBC_CFG_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_q <= DBC_CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    wire logic active = (mode == DBC_MODE_NORMAL) || (mode == DBC_MODE_STOP)
        || (mode == DBC_MODE_RESTART);

    // ----------------------------------------------------------------
    // Boost hysteretic control
    // ----------------------------------------------------------------
    logic boost_run_q, boost_run_d;
    logic below_th, above_hys, boost_allowed;

    always_comb begin
        // Restart keeps the setting made in normal mode
        boost_allowed = active && cfg_q[DBC_CFG_BOOST_EN];
        below_th = cfg_q[DBC_CFG_BOOST_V] ? sync2_q.sensed_battery_level_below_th1
            : sync2_q.sensed_battery_level_below_th2;
        above_hys = cfg_q[DBC_CFG_BOOST_V] ? sync2_q.sensed_battery_level_above_hys1
            : sync2_q.sensed_battery_level_above_hys2;
        boost_run_d = boost_run_q;
        if (!boost_allowed) begin
            boost_run_d = 1'b0;
        end else if (below_th) begin
            boost_run_d = 1'b1;
        end else if (above_hys) begin
            boost_run_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            boost_run_q <= 1'b0;
        end else begin
            boost_run_q <= boost_run_d;
        end
    end

    // ----------------------------------------------------------------
    // Buck modulation and soft start
    // ----------------------------------------------------------------
    dbc_buck_e bk_q, bk_d;
    dbc_mode_e mode_q;
    logic [7:0] duty_q, duty_d;
    logic [7:0] per_q, per_d;
    logic [7:0] hold_q, hold_d;
    logic first_q;
    logic pwm_req, surge_set, wake_pfm;

    always_comb begin
        bk_d = bk_q;
        duty_d = duty_q;
        per_d = per_q;
        hold_d = hold_q;
        surge_set = 1'b0;
        // Manual switch by the wake pin, else auto switch on overload
        pwm_req = cfg_q[DBC_CFG_PWM_BY_WAKE] && wake_pin;
        // A low wake pin hands the buck back to PFM while the pin has control
        wake_pfm = cfg_q[DBC_CFG_PWM_BY_WAKE] && !wake_pin;
        if (!active) begin
            bk_d = DBC_BK_OFF;
        end else begin
            case (bk_q)
                DBC_BK_OFF: begin
                    // Power-up, or sleep/fail-safe into restart
                    if (mode == DBC_MODE_RESTART || first_q) begin
                        bk_d = DBC_BK_SOFT;
                    end else begin
                        bk_d = DBC_BK_PWM;
                    end
                    duty_d = DBC_DUTY_MIN;
                    per_d = '0;
                    hold_d = '0;
                end
                DBC_BK_SOFT: begin
                    if (sync2_q.buck_out_reached) begin
                        bk_d = (mode == DBC_MODE_STOP) ? DBC_BK_PFM : DBC_BK_PWM;
                    end else if (per_q == DBC_SW_CYCLES - 8'h01) begin
                        per_d = '0;
                        if (hold_q == DBC_HOLD_PERIODS - 8'h01) begin
                            hold_d = '0;
                            duty_d = (duty_q > DBC_DUTY_FULL - DBC_DUTY_STEP) ? DBC_DUTY_FULL
                                : duty_q + DBC_DUTY_STEP;
                        end else begin
                            hold_d = hold_q + 8'h01;
                        end
                    end else begin
                        per_d = per_q + 8'h01;
                    end
                end
                DBC_BK_PWM: begin
                    duty_d = DBC_DUTY_FULL;
                    if (mode == DBC_MODE_STOP
                        && (mode_q != DBC_MODE_STOP || stop_cmd || wake_pfm)) begin
                        bk_d = DBC_BK_PFM;
                    end
                end
                DBC_BK_PFM: begin
                    if (mode != DBC_MODE_STOP) begin
                        bk_d = DBC_BK_PWM;
                    end else if (pwm_req) begin
                        bk_d = DBC_BK_PWM;
                    end else if (cfg_q[DBC_CFG_PWM_AUTO] && !cfg_q[DBC_CFG_PWM_BY_WAKE]
                        && sync2_q.load_over_pfm) begin
                        // Under wake-pin control the pin alone decides, so no ping-pong
                        bk_d = DBC_BK_PWM;
                        surge_set = 1'b1;
                    end
                end
                default: bk_d = DBC_BK_OFF;
            endcase
            // Every way into PWM lifts the duty limit to full on-time at once
            if (bk_d == DBC_BK_PWM) begin
                duty_d = DBC_DUTY_FULL;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bk_q <= DBC_BK_OFF;
            mode_q <= DBC_MODE_SLEEP;
            duty_q <= DBC_DUTY_MIN;
            per_q <= '0;
            hold_q <= '0;
            first_q <= 1'b1;
        end else begin
            bk_q <= bk_d;
            mode_q <= mode;
            duty_q <= duty_d;
            per_q <= per_d;
            hold_q <= hold_d;
            first_q <= first_q && !active;
        end
    end

    // ----------------------------------------------------------------
    // Sticky status flags; set wins over clear
    // ----------------------------------------------------------------
    logic [DBC_FLT_W-1:0] flt_q, flt_d, flt_set;
    logic surge_q, surge_d;

    always_comb begin
        flt_set = '0;
        flt_set[DBC_FLT_BCK_OPEN] = sync2_q.buck_sw_open;
        flt_set[DBC_FLT_BCK_SHORT] = sync2_q.buck_sw_short;
        flt_set[DBC_FLT_BCK_RANGE] = sync2_q.buck_out_of_range;
        flt_set[DBC_FLT_BST_OPEN] = sync2_q.boost_open;
        flt_set[DBC_FLT_BST_SHORT] = sync2_q.boost_short;
        flt_set[DBC_FLT_BST_GND] = sync2_q.boost_gnd_loss;
        flt_set[DBC_FLT_STEP_UP_RUNNING_FLAG] = boost_run_d && !boost_run_q;
        flt_d = flt_q;
        if (wr_flt) begin
            flt_d = flt_q & ~reg_wdata[DBC_FLT_W-1:0];
            // Boost-active only clears while supply sits above threshold
            if (below_th) begin
                flt_d[DBC_FLT_STEP_UP_RUNNING_FLAG] = flt_q[DBC_FLT_STEP_UP_RUNNING_FLAG];
            end
        end
        flt_d = flt_d | flt_set;
        surge_d = surge_q;
        if (wr_wk && reg_wdata[DBC_WK_SURGE]) begin
            surge_d = 1'b0;
        end
        surge_d = surge_d | surge_set;
    end

    // Flags feed only the read path, never mode or config
    always_ff @(posedge clk) begin
        if (srst) begin
            flt_q <= '0;
            surge_q <= 1'b0;
        end else begin
            flt_q <= flt_d;
            surge_q <= surge_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs and read port
    // ----------------------------------------------------------------
    dbc_ctrl_s ctrl_q, ctrl_d;
    logic surge_ev_q;
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        ctrl_d.buck_en = active && bk_d != DBC_BK_OFF;
        ctrl_d.buck_pwm = bk_d == DBC_BK_PWM || bk_d == DBC_BK_SOFT;
        ctrl_d.buck_duty_max = duty_d;
        ctrl_d.buck_loop_closed = bk_d == DBC_BK_PWM || bk_d == DBC_BK_PFM;
        ctrl_d.boost_en = boost_allowed;
        ctrl_d.boost_run = boost_run_d;
        ctrl_d.boost_vsel = cfg_q[DBC_CFG_BOOST_V];
        ctrl_d.boost_duty_cut = boost_run_d && sync2_q.boost_peak_oc;
        rdata_d = '0;
        if (reg_rd) begin
            case (reg_addr)
                DBC_ADDR_HW_CONFIG: rdata_d = cfg_q;
                DBC_ADDR_FAULT_STAT: rdata_d = 8'(flt_q);
                DBC_ADDR_WAKE_STAT: rdata_d = 8'(surge_q);
                DBC_ADDR_STATE: rdata_d = {boost_run_q, 3'(mode_q), 2'h0, 2'(bk_q)};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= '0;
            surge_ev_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            surge_ev_q <= surge_set;
            rdata_q <= rdata_d;
        end
    end

    assign ctrl = ctrl_q;
    assign surge_event = surge_ev_q;
    assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

// ==== hdl/dbc_pkg.sv ====
// Package: constants, types and register map of the cascaded converter control
package dbc_pkg;

    // Operating modes from the system mode controller
    typedef enum logic [2:0] {
        DBC_MODE_SLEEP = 3'h0,
        DBC_MODE_RESTART = 3'h1,
        DBC_MODE_NORMAL = 3'h3,
        DBC_MODE_STOP = 3'h2,
        DBC_MODE_FAILSAFE = 3'h6
    } dbc_mode_e;

    // Buck control states, Gray coded along off, soft start, pwm, pfm
    typedef enum logic [1:0] {
        DBC_BK_OFF = 2'h0,
        DBC_BK_SOFT = 2'h1,
        DBC_BK_PWM = 2'h3,
        DBC_BK_PFM = 2'h2
    } dbc_buck_e;

    // Register indices (word addresses)
    localparam logic [3:0] DBC_ADDR_HW_CONFIG = 4'h0;
    localparam logic [3:0] DBC_ADDR_FAULT_STAT = 4'h1;
    localparam logic [3:0] DBC_ADDR_WAKE_STAT = 4'h2;
    localparam logic [3:0] DBC_ADDR_STATE = 4'h3;

    // hardware_config_register fields
    localparam int DBC_CFG_BOOST_EN = 0;
    localparam int DBC_CFG_BOOST_V = 1;
    localparam int DBC_CFG_PWM_AUTO = 2;
    localparam int DBC_CFG_PWM_BY_WAKE = 3;
    localparam logic [7:0] DBC_CFG_RESET = 8'h04;
    localparam logic [7:0] DBC_CFG_MASK = 8'h0F;

    // converter_fault_status fields
    localparam int DBC_FLT_BCK_OPEN = 0;
    localparam int DBC_FLT_BCK_SHORT = 1;
    localparam int DBC_FLT_BCK_RANGE = 2;
    localparam int DBC_FLT_BST_OPEN = 3;
    localparam int DBC_FLT_BST_SHORT = 4;
    localparam int DBC_FLT_BST_GND = 5;
    localparam int DBC_FLT_STEP_UP_RUNNING_FLAG = 6;
    localparam int DBC_FLT_W = 7;

    // Wake status: load_surge_flag
    localparam int DBC_WK_SURGE = 0;

    // Soft start: duty is 8 bits, full scale is 100 % on time
    localparam logic [7:0] DBC_DUTY_MIN = 8'h08;
    localparam logic [7:0] DBC_DUTY_STEP = 8'h08;
    localparam logic [7:0] DBC_DUTY_FULL = 8'hFF;
    localparam logic [7:0] DBC_HOLD_PERIODS = 8'h04;

    // Switching period: 2.5 us at 40 MHz
    localparam int DBC_CLK_MHZ = 40;
    localparam int DBC_SW_PERIOD_NS = 2500;
    localparam logic [7:0] DBC_SW_CYCLES = 8'((DBC_SW_PERIOD_NS * DBC_CLK_MHZ) / 1000);

    // Analog comparator bundle, asynchronous to clk
    typedef struct packed {
        logic sensed_battery_level_below_th1;
        logic sensed_battery_level_above_hys1;
        logic sensed_battery_level_below_th2;
        logic sensed_battery_level_above_hys2;
        logic buck_out_reached;
        logic buck_out_of_range;
        logic buck_sw_open;
        logic buck_sw_short;
        logic boost_open;
        logic boost_short;
        logic boost_gnd_loss;
        logic boost_peak_oc;
        logic load_over_pfm;
    } dbc_comp_s;

    localparam int DBC_COMP_W = $bits(dbc_comp_s);

    // Controls toward the power stages
    typedef struct packed {
        logic buck_en;
        logic buck_pwm;
        logic [7:0] buck_duty_max;
        logic buck_loop_closed;
        logic boost_en;
        logic boost_run;
        logic boost_vsel;
        logic boost_duty_cut;
    } dbc_ctrl_s;

endpackage

// ==== test/dbc_ctrl_assertions.sv ====
// Port checker of the converter control block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
// ------
// Checker
// ------
module dbc_ctrl_checker
    import dbc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Mode and analog side
    input wire dbc_mode_e mode,
    input wire logic stop_cmd,
    input wire logic wake_pin,
    input wire dbc_comp_s comp,
    input wire dbc_ctrl_s ctrl,
    input wire logic surge_event
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic off_m;
    logic on_m;
    assign off_m = mode == DBC_MODE_SLEEP || mode == DBC_MODE_FAILSAFE;
    assign on_m = mode == DBC_MODE_NORMAL || mode == DBC_MODE_STOP || mode == DBC_MODE_RESTART;
    // Four or five cycles cover two synchroniser flops plus the output register
    sequence s_settled_pwm;
        mode == DBC_MODE_NORMAL && ctrl.buck_loop_closed;
    endsequence
    sequence s_quiet_stop;
        (mode == DBC_MODE_STOP && !comp.load_over_pfm && !wake_pin) [*5];
    endsequence
    sequence s_oc_rise;
        !comp.boost_peak_oc [*3] ##1 comp.boost_peak_oc;
    endsequence
    AST_OFF_MODES: assert property (off_m [*4] |-> !ctrl.buck_en && !ctrl.boost_en)
        else $error("converter enabled in sleep or fail-safe");
    AST_ON_MODES: assert property (on_m [*4] |-> ctrl.buck_en)
        else $error("buck disabled in an active mode");
    AST_PWM_NORMAL: assert property (s_settled_pwm [*4] |-> ctrl.buck_pwm)
        else $error("buck not in pwm in normal mode");
    AST_STOP_PFM: assert property (s_settled_pwm ##1 s_quiet_stop |-> !ctrl.buck_pwm)
        else $error("buck kept pwm after stop entry");
    AST_FULL_DUTY: assert property (ctrl.buck_loop_closed && ctrl.buck_pwm |-> ctrl.buck_duty_max == DBC_DUTY_FULL)
        else $error("pwm duty limit below full scale");
    AST_SOFT_START: assert property ($rose(ctrl.buck_en) |-> ctrl.buck_duty_max == DBC_DUTY_MIN && !ctrl.buck_loop_closed)
        else $error("buck start not at minimum duty");
    AST_SURGE_PULSE: assert property (surge_event |-> ctrl.buck_pwm ##1 !surge_event)
        else $error("surge event not a single pulse in pwm");
    AST_BOOST_GATE: assert property (!ctrl.boost_en |-> !ctrl.boost_run)
        else $error("boost running while disabled");
    AST_BOOST_START: assert property ((ctrl.boost_en && ctrl.boost_vsel && comp.sensed_battery_level_below_th1) [*4] |-> ctrl.boost_run)
        else $error("boost idle below first threshold");
    AST_BOOST_STOP: assert property ((!ctrl.boost_vsel && comp.sensed_battery_level_above_hys2) [*4] |-> !ctrl.boost_run)
        else $error("boost running above second hysteresis");
    AST_DUTY_CUT: assert property ((comp.boost_peak_oc && ctrl.boost_run) [*4] |-> ctrl.boost_duty_cut)
        else $error("no duty cut on peak overcurrent");
    AST_SYNC_DELAY: assert property (s_oc_rise |-> !ctrl.boost_duty_cut ##1 !ctrl.boost_duty_cut)
        else $error("comparator used without synchroniser");
endmodule
bind dbc_ctrl dbc_ctrl_checker u_dbc_chk (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .mode, .stop_cmd, .wake_pin, .comp, .ctrl, .surge_event);
`default_nettype wire

// ==== test/dbc_stage_model.sv ====
// Behavioural model of the analog comparators and power stages
`timescale 1ns/1ps
`default_nettype none
// ------
// Stage model
// ------
module dbc_stage_model
    import dbc_pkg::*;
#(
    parameter int TH1 = 100,
    parameter int HYS1 = 20,
    parameter int TH2 = 80,
    parameter int HYS2 = 10,
    parameter logic [7:0] REACH_DUTY = 8'h18
)
(
    // Control from the block
    input wire dbc_ctrl_s ctrl,
    // Bench controls
    input wire logic [7:0] batt_lvl,
    input wire logic load_high,
    input wire logic peak_oc,
    input wire logic [5:0] pin_fault,
    // Comparator levels
    output var dbc_comp_s comp
);
    logic reached;
    // Target counts as reached only once the ramp has climbed two steps
    assign reached = ctrl.buck_en && ctrl.buck_duty_max >= REACH_DUTY;
    // Levels move off the clock grid, as real comparators do
    assign #3 comp = {(batt_lvl < TH1), (batt_lvl > TH1 + HYS1), (batt_lvl < TH2),
        (batt_lvl > TH2 + HYS2), reached, pin_fault[2], pin_fault[0], pin_fault[1],
        pin_fault[3], pin_fault[4], pin_fault[5], peak_oc, load_high};
endmodule
`default_nettype wire

// ==== test/dcdc_buck_boost_control_tb_top.sv ====
// Self-checking testbench of the cascaded converter control
`timescale 1ns/1ps
`default_nettype none
// ------
// Bench top
// ------
module dcdc_buck_boost_control_tb_top
    import dbc_pkg::*;
;
    logic clk;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    dbc_mode_e mode = DBC_MODE_SLEEP;
    logic stop_cmd = 1'b0;
    logic wake_pin = 1'b0;
    dbc_comp_s comp;
    dbc_ctrl_s ctrl;
    logic surge_event;
    logic [7:0] batt_lvl = 8'hC8;
    logic load_high = 1'b0;
    logic peak_oc = 1'b0;
    logic [5:0] pin_fault = 6'h00;
    int mismatches = 0;
    int checks_done = 0;
    int surges = 0;
    int exp_flt;
    int i;
    dbc_mode_e modes[$] = '{DBC_MODE_NORMAL, DBC_MODE_STOP, DBC_MODE_SLEEP, DBC_MODE_RESTART,
        DBC_MODE_FAILSAFE, DBC_MODE_RESTART};
    dbc_ctrl DUT (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mode,
        .stop_cmd, .wake_pin, .comp, .ctrl, .surge_event);
    dbc_stage_model u_stage (.ctrl, .batt_lvl, .load_high, .peak_oc, .pin_fault, .comp);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (surge_event === 1'b1) surges++;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic chkr(input string n, input logic [3:0] a, input logic [7:0] e);
        @(posedge clk) reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk) reg_rd <= 1'b0;
        @(negedge clk) checks_done++;
        if (reg_rdata !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, reg_rdata);
        end
    endtask
    task automatic chkb(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic settle;
        repeat (8) @(negedge clk);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        void'($urandom(94007));
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        chkr("config", DBC_ADDR_HW_CONFIG, DBC_CFG_RESET);
        chkr("fault_status", DBC_ADDR_FAULT_STAT, 8'h00);
        wr(4'h5, 8'hFF);
        chkr("unmapped", 4'h5, 8'h00);
        wr(DBC_ADDR_HW_CONFIG, 8'hFF);
        chkr("config", DBC_ADDR_HW_CONFIG, DBC_CFG_MASK);
        wr(DBC_ADDR_HW_CONFIG, DBC_CFG_RESET);
        $display("registers done");
        @(posedge clk) mode <= DBC_MODE_RESTART;
        for (i = 0; i < 10 && ctrl.buck_en !== 1'b1; i++) @(negedge clk);
        chkb("buck_en", 1'b1, ctrl.buck_en);
        chkb("duty_min", 1'b1, ctrl.buck_duty_max === DBC_DUTY_MIN);
        repeat (int'(DBC_HOLD_PERIODS) * int'(DBC_SW_CYCLES) - 10) @(negedge clk);
        chkb("duty_hold", 1'b1, ctrl.buck_duty_max === DBC_DUTY_MIN);
        repeat (20) @(negedge clk);
        chkb("duty_step", 1'b1, ctrl.buck_duty_max === DBC_DUTY_MIN + DBC_DUTY_STEP);
        for (i = 0; i < 3000 && ctrl.buck_loop_closed !== 1'b1; i++) @(negedge clk);
        if (i == 3000) begin
            mismatches++;
            test_done();
        end
        chkb("duty_full", 1'b1, ctrl.buck_duty_max === DBC_DUTY_FULL);
        @(posedge clk) mode <= DBC_MODE_NORMAL;
        settle();
        chkb("buck_pwm", 1'b1, ctrl.buck_pwm);
        @(posedge clk) mode <= DBC_MODE_STOP;
        settle();
        chkb("buck_pwm", 1'b0, ctrl.buck_pwm);
        chkr("state", DBC_ADDR_STATE, 8'h22);
        $display("buck sequencing done");
        wr(DBC_ADDR_HW_CONFIG, 8'h00);
        @(posedge clk) load_high <= 1'b1;
        settle();
        chkb("buck_pwm", 1'b0, ctrl.buck_pwm);
        wr(DBC_ADDR_HW_CONFIG, 8'h04);
        settle();
        chkb("buck_pwm", 1'b1, ctrl.buck_pwm);
        chkb("surge_count", 1'b1, surges == 1);
        chkr("wake_status", DBC_ADDR_WAKE_STAT, 8'h01);
        wr(DBC_ADDR_WAKE_STAT, 8'h01);
        chkr("wake_status", DBC_ADDR_WAKE_STAT, 8'h00);
        @(posedge clk) load_high <= 1'b0;
        settle();
        chkb("buck_pwm", 1'b1, ctrl.buck_pwm);
        @(posedge clk) stop_cmd <= 1'b1;
        @(posedge clk) stop_cmd <= 1'b0;
        settle();
        chkb("buck_pwm", 1'b0, ctrl.buck_pwm);
        wr(DBC_ADDR_HW_CONFIG, 8'h0C);
        @(posedge clk) wake_pin <= 1'b1;
        settle();
        chkb("buck_pwm", 1'b1, ctrl.buck_pwm);
        @(posedge clk) wake_pin <= 1'b0;
        settle();
        chkb("buck_pwm", 1'b0, ctrl.buck_pwm);
        $display("stop mode done");
        @(posedge clk) mode <= DBC_MODE_NORMAL;
        wr(DBC_ADDR_HW_CONFIG, 8'h07);
        settle();
        chkb("boost_en", 1'b1, ctrl.boost_en);
        chkb("boost_vsel", 1'b1, ctrl.boost_vsel);
        chkb("boost_run", 1'b0, ctrl.boost_run);
        @(posedge clk) batt_lvl <= 8'h5A;
        settle();
        chkb("boost_run", 1'b1, ctrl.boost_run);
        wr(DBC_ADDR_FAULT_STAT, 8'h40);
        chkr("fault_status", DBC_ADDR_FAULT_STAT, 8'h40);
        @(posedge clk) batt_lvl <= 8'h6E;
        @(posedge clk) peak_oc <= 1'b1;
        settle();
        chkb("boost_run", 1'b1, ctrl.boost_run);
        chkb("duty_cut", 1'b1, ctrl.boost_duty_cut);
        @(posedge clk) peak_oc <= 1'b0;
        wr(DBC_ADDR_FAULT_STAT, 8'h40);
        chkr("fault_status", DBC_ADDR_FAULT_STAT, 8'h00);
        @(posedge clk) batt_lvl <= 8'h82;
        settle();
        chkb("boost_run", 1'b0, ctrl.boost_run);
        wr(DBC_ADDR_HW_CONFIG, 8'h05);
        @(posedge clk) batt_lvl <= 8'h5A;
        settle();
        chkb("boost_run", 1'b0, ctrl.boost_run);
        @(posedge clk) batt_lvl <= 8'h46;
        @(posedge clk) mode <= DBC_MODE_STOP;
        settle();
        chkb("boost_run", 1'b1, ctrl.boost_run);
        @(posedge clk) batt_lvl <= 8'h5F;
        settle();
        chkb("boost_run", 1'b0, ctrl.boost_run);
        wr(DBC_ADDR_FAULT_STAT, 8'h40);
        $display("boost done");
        for (i = 0; i < 3; i++) begin
            exp_flt = $urandom % 63 + 1;
            @(posedge clk) pin_fault <= 6'(exp_flt);
            settle();
            @(posedge clk) pin_fault <= 6'h00;
            settle();
            chkr("fault_status", DBC_ADDR_FAULT_STAT, 8'(exp_flt));
            chkr("config", DBC_ADDR_HW_CONFIG, 8'h05);
            chkb("buck_en", 1'b1, ctrl.buck_en);
            wr(DBC_ADDR_FAULT_STAT, 8'h3F);
            chkr("fault_status", DBC_ADDR_FAULT_STAT, 8'h00);
        end
        $display("faults done");
        foreach (modes[k]) begin
            @(posedge clk) mode <= modes[k];
            settle();
            chkb("buck_en", !(modes[k] inside {DBC_MODE_SLEEP, DBC_MODE_FAILSAFE}), ctrl.buck_en);
        end
        $display("modes done");
        test_done();
    end
endmodule
`default_nettype wire
